/* File: verilog/tcs_pkg.sv */
// Constants shared by the trip circuit supervisor and its helper modules
package tcs_pkg;

  // ----------------------------------------------------------------
  // Clock and sampling timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_KHZ = 100_000;               // System clock rate in kHz
  localparam int SAMPLE_PERIOD_MS = 600;               // Interval between condition checks
  localparam int SAMPLE_PERIOD_CYC = CLK_FREQ_KHZ * SAMPLE_PERIOD_MS;
  localparam int TWO_INPUT_DELAY_MS = 1800;            // Nominal report delay, two inputs
  localparam int ONE_INPUT_DELAY_S = 300;              // Nominal report delay, one input

  // ----------------------------------------------------------------
  // Consecutive abnormal sample thresholds (fixed, not settable)
  // ----------------------------------------------------------------
  localparam int RUN_W = 9;                            // Width of the run counter
  localparam logic [8:0] TWO_INPUT_SAMPLES = 9'h003;   // Three checks
  localparam logic [8:0] ONE_INPUT_SAMPLES = 9'h1F4;   // Five hundred checks

  // ----------------------------------------------------------------
  // Monitoring mode encoding
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_DISABLED = 2'h0;
  localparam logic [1:0] MODE_TWO_INPUTS = 2'h1;
  localparam logic [1:0] MODE_ONE_INPUT = 2'h2;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and field positions
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] CFG_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFFSET = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h0C;
  localparam int CFG_MODE_LSB = 0;                     // Mode field, 2 bits
  localparam int CFG_ENABLE_BIT = 2;                   // Supervision on/off
  localparam int CFG_TRIP_ASSIGNED_BIT = 3;            // Trip contact input allocated
  localparam int CFG_AUX_ASSIGNED_BIT = 4;             // Breaker aux input allocated
  localparam int CFG_W = 5;
  localparam logic [4:0] CFG_RESET = 5'h04;            // Disabled mode, enable on
  localparam int ST_FAIL_BIT = 0;
  localparam int ST_OFF_BIT = 1;
  localparam int ST_BLOCKED_BIT = 2;
  localparam int ST_ACTIVE_BIT = 3;
  localparam int ST_PROG_FAIL_BIT = 4;
  localparam int ST_RUN_LSB = 16;
  localparam int IRQ_W = 3;
  localparam int IRQ_FAIL_SET_BIT = 0;                 // Annunciation raised
  localparam int IRQ_FAIL_CLR_BIT = 1;                 // Annunciation withdrawn
  localparam int IRQ_MISMATCH_BIT = 2;                 // Configuration mismatch appeared
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Supervision states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SUPV_OFF, SUPV_BLOCKED, SUPV_ACTIVE} supv_state_t;

endpackage

/* File: verilog/tcs_tick_divider.sv */
// Divider that emits a one-cycle sampling enable every PERIOD clocks
`timescale 1ns/10ps
module tcs_tick_divider #(
  parameter int PERIOD = 60_000_000
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);

  // ----------------------------------------------------------------
  // Free running count, wraps at PERIOD
  // ----------------------------------------------------------------
  logic [31:0] cnt_ff; // Cycles since last tick
  logic [31:0] nxt_cnt; // Next count
  logic tick_ff; // Registered tick
  wire wrap = (cnt_ff == 32'(PERIOD - 1)); // Last cycle of a period

  assign nxt_cnt = wrap ? 32'h0000_0000 : cnt_ff + 32'h0000_0001;
  assign tick = tick_ff;

  // Counter and pulse register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 32'h0000_0000;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= wrap;
    end
  end

endmodule

/* File: verilog/tcs_run_counter.sv */
// Counter of consecutive abnormal samples with a fixed threshold
`timescale 1ns/10ps
module tcs_run_counter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic sample,
  input wire logic abnormal,
  input wire logic [8:0] threshold,
  output logic [8:0] count,
  output logic reached
);

  // ----------------------------------------------------------------
  // Run length register
  // ----------------------------------------------------------------
  logic [8:0] count_ff; // Current run length
  logic [8:0] nxt_count; // Next run length
  wire at_top = (count_ff >= threshold); // Saturated at threshold

  // A healthy sample ends the run; saturation keeps the flag steady
  assign nxt_count = clear ? 9'h000 :
                     !sample ? count_ff :
                     !abnormal ? 9'h000 :
                     at_top ? threshold : count_ff + 9'h001;
  assign count = count_ff;
  assign reached = at_top && (threshold != 9'h000);

  // Run register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= 9'h000;
    end else begin
      count_ff <= nxt_count;
    end
  end

endmodule

/* File: verilog/trip_circuit_supervisor.sv */
// Trip circuit supervisor: sampling, fault run detection, register port and interrupt
`timescale 1ns/10ps

// Overview of operation
// R1: Two inputs: trip high is healthy, both-low abnormal
// R2: Trip closed, both sense low means faulty
// R3: Two inputs sampled every 600 ms
// R4: Two inputs: three abnormal samples raise failure
// R5: Two inputs: failure clears when fault gone
// R6: One input: high is healthy, low trip closed
// R7: One input: 500 low samples raise failure
// R8: One input: failure clears on recovery
// R9: Momentary trip or system fault never annunciates
// R10: Mode setting selects two, one or disabled
// R11: Separate on/off enable for supervision
// R12: Input allocation mismatch raises configuration message
// R13: Report delay fixed, spans longest trip
// R14: Report off, blocked, active, configuration fault
// R15: Healthy sample resets abnormal run counter
module trip_circuit_supervisor #(
  parameter int SAMPLE_PERIOD_CYC = tcs_pkg::SAMPLE_PERIOD_CYC
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic TRIP_CONTACT_SENSE_INPUT,
  input wire logic BREAKER_AUX_SENSE_INPUT,
  input wire logic BLOCK_INPUT,
  input wire logic SYSTEM_FAULT,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic FAIL_ANNUNCIATION,
  output logic SUPV_OFF_STATE,
  output logic SUPV_BLOCKED_STATE,
  output logic SUPV_ACTIVE_STATE,
  output logic CONFIG_MISMATCH,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Pins come from contact wiring and other logic, so two stages each
  logic [3:0] meta_ff; // First stage, read only by second stage
  logic [3:0] sync_ff; // Second stage, safe to use
  wire trip_s = sync_ff[0]; // Trip contact sense, synced
  wire aux_s = sync_ff[1]; // Breaker aux sense, synced
  wire block_s = sync_ff[2]; // External block, synced
  wire sysflt_s = sync_ff[3]; // System fault in progress, synced

  // Two flop synchroniser for all four pins
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      meta_ff <= 4'h0;
      sync_ff <= 4'h0;
    end else begin
      meta_ff <= {SYSTEM_FAULT, BLOCK_INPUT, BREAKER_AUX_SENSE_INPUT, TRIP_CONTACT_SENSE_INPUT};
      sync_ff <= meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Configuration register fields
  // ----------------------------------------------------------------
  logic [4:0] cfg_ff; // Mode, enable and input allocation
  logic [4:0] nxt_cfg; // Next configuration
  wire [1:0] mode = cfg_ff[tcs_pkg::CFG_MODE_LSB +: 2]; // Selected mode
  wire enable = cfg_ff[tcs_pkg::CFG_ENABLE_BIT]; // On/off setting
  wire trip_assigned = cfg_ff[tcs_pkg::CFG_TRIP_ASSIGNED_BIT]; // Trip input allocated
  wire aux_assigned = cfg_ff[tcs_pkg::CFG_AUX_ASSIGNED_BIT]; // Aux input allocated
  wire mode_two = (mode == tcs_pkg::MODE_TWO_INPUTS); // see R10
  wire mode_one = (mode == tcs_pkg::MODE_ONE_INPUT); // see R10
  wire mode_on = mode_two || mode_one; // Reserved code acts as disabled

  // Allocation must equal what the mode needs
  wire mismatch = (mode_two && !(trip_assigned && aux_assigned)) ||
                  (mode_one && !(trip_assigned && !aux_assigned)); // see R12

  // ----------------------------------------------------------------
  // Supervision state
  // ----------------------------------------------------------------
  tcs_pkg::supv_state_t state_ff; // Registered state
  tcs_pkg::supv_state_t nxt_state; // Next state
  logic prog_fail_ff; // Registered mismatch flag

  // Off unless mode and enable both on; mismatch or block forces blocked
  assign nxt_state = (!mode_on || !enable) ? tcs_pkg::SUPV_OFF :
                     (mismatch || block_s) ? tcs_pkg::SUPV_BLOCKED :
                     tcs_pkg::SUPV_ACTIVE; // see R10, R11, R14

  wire active = (state_ff == tcs_pkg::SUPV_ACTIVE); // Supervision running

  // State outputs decoded from the state register
  logic off_q; // Off state decoded
  logic blocked_q; // Blocked state decoded
  logic active_q; // Active state decoded
  always_comb begin
    off_q = 1'b0;
    blocked_q = 1'b0;
    active_q = 1'b0;
    case (state_ff)
      tcs_pkg::SUPV_OFF: off_q = 1'b1; // see R14
      tcs_pkg::SUPV_BLOCKED: blocked_q = 1'b1; // see R14
      tcs_pkg::SUPV_ACTIVE: active_q = 1'b1; // see R14
      default: off_q = 1'b1; // Unknown code treated as off
    endcase
  end

  // State and mismatch registers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= tcs_pkg::SUPV_OFF;
      prog_fail_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      prog_fail_ff <= mismatch && enable; // see R12
    end
  end

  assign SUPV_OFF_STATE = off_q;
  assign SUPV_BLOCKED_STATE = blocked_q;
  assign SUPV_ACTIVE_STATE = active_q;
  assign CONFIG_MISMATCH = prog_fail_ff;

  // ----------------------------------------------------------------
  // Sampling and classification
  // ----------------------------------------------------------------
  logic tick; // One cycle every sampling period

  // Same period for both modes
  // The divider runs free, so the first check after enabling lands
  // anywhere within one period and the report delay varies by that much
  tcs_tick_divider #(
    .PERIOD(SAMPLE_PERIOD_CYC)
  ) u_tick (
    .clk(CLK),
    .rst_n(RST_N),
    .tick(tick) // see R3, R7
  );

  // Both low is abnormal in two-input mode, whatever the breaker position
  wire abnormal_two = !trip_s && !aux_s; // see R1, R2
  // Low on the single input means trip contact closed or circuit broken
  wire abnormal_one = !trip_s; // see R6
  wire abnormal = mode_two ? abnormal_two : abnormal_one;

  // No checks are taken while a system fault is in progress
  wire sample = tick && active && !sysflt_s; // see R9

  // Threshold is a constant per mode so the delay cannot be retuned
  wire [8:0] threshold = mode_two ? tcs_pkg::TWO_INPUT_SAMPLES : tcs_pkg::ONE_INPUT_SAMPLES; // see R13

  // Restart the run on mode change or when supervision leaves active
  // Carrying a run across modes would judge it against the wrong threshold
  logic [1:0] mode_last_ff; // Mode seen last cycle
  wire run_clear = !active || (mode != mode_last_ff);

  logic [8:0] run_cnt; // Consecutive abnormal samples
  logic run_reached; // Threshold reached

  // One counter shared by both modes, threshold picks the delay
  tcs_run_counter u_run (
    .clk(CLK),
    .rst_n(RST_N),
    .clear(run_clear),
    .sample(sample),
    .abnormal(abnormal), // see R15
    .threshold(threshold), // see R4, R7
    .count(run_cnt),
    .reached(run_reached)
  );

  // ----------------------------------------------------------------
  // Failure annunciation
  // ----------------------------------------------------------------
  // Follows the run counter, so a healthy check withdraws it
  // Leaving active or changing mode drops it at once
  logic fail_ff; // Annunciation register
  wire nxt_fail = run_reached && active && !run_clear; // see R4, R5, R7, R8

  // Annunciation and mode history
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      fail_ff <= 1'b0;
      mode_last_ff <= tcs_pkg::MODE_DISABLED;
    end else begin
      fail_ff <= nxt_fail;
      mode_last_ff <= mode;
    end
  end

  assign FAIL_ANNUNCIATION = fail_ff;

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  wire sel_cfg = (ADDR == tcs_pkg::CFG_OFFSET); // Config select
  wire sel_status = (ADDR == tcs_pkg::STATUS_OFFSET); // Status select
  wire sel_istat = (ADDR == tcs_pkg::IRQ_STAT_OFFSET); // Interrupt status select
  wire sel_imask = (ADDR == tcs_pkg::IRQ_MASK_OFFSET); // Interrupt mask select
  wire wr_cfg = WR && sel_cfg; // Config write
  wire wr_istat = WR && sel_istat; // Write one to clear
  wire wr_imask = WR && sel_imask; // Mask write

  assign nxt_cfg = wr_cfg ? WDATA[tcs_pkg::CFG_W-1:0] : cfg_ff; // see R10, R11

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  logic [2:0] irq_stat_ff; // Sticky event bits
  logic [2:0] irq_mask_ff; // Enable per event
  logic prog_fail_last_ff; // Previous mismatch flag
  logic [2:0] irq_event; // Events this cycle
  logic [2:0] nxt_irq_stat; // Next sticky bits
  logic [2:0] irq_clr; // Bits software clears

  assign irq_event[tcs_pkg::IRQ_FAIL_SET_BIT] = nxt_fail && !fail_ff;
  assign irq_event[tcs_pkg::IRQ_FAIL_CLR_BIT] = !nxt_fail && fail_ff;
  assign irq_event[tcs_pkg::IRQ_MISMATCH_BIT] = prog_fail_ff && !prog_fail_last_ff; // see R12
  assign irq_clr = wr_istat ? WDATA[tcs_pkg::IRQ_W-1:0] : 3'h0;
  // A new event beats a clear in the same cycle
  // Losing an event to a clear would hide a failure from software
  assign nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_event;
  assign IRQ = |(irq_stat_ff & irq_mask_ff);

  // Configuration and interrupt registers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_ff <= tcs_pkg::CFG_RESET;
      irq_stat_ff <= tcs_pkg::IRQ_RESET;
      irq_mask_ff <= tcs_pkg::IRQ_RESET;
      prog_fail_last_ff <= 1'b0;
    end else begin
      cfg_ff <= nxt_cfg;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= wr_imask ? WDATA[tcs_pkg::IRQ_W-1:0] : irq_mask_ff;
      prog_fail_last_ff <= prog_fail_ff;
    end
  end

  // ----------------------------------------------------------------
  // Read data, valid in the cycle after the strobe only
  // ----------------------------------------------------------------
  logic [31:0] status_word; // Live status view
  logic [31:0] rd_mux; // Selected read value
  logic [31:0] rdata_ff; // Registered read data

  assign status_word = {7'h00, run_cnt, 11'h000, prog_fail_ff, active_q, blocked_q, off_q, fail_ff};
  // Unmapped addresses read as zero
  assign rd_mux = sel_cfg ? {27'h000_0000, cfg_ff} :
                  sel_status ? status_word :
                  sel_istat ? {29'h0000_0000, irq_stat_ff} :
                  sel_imask ? {29'h0000_0000, irq_mask_ff} : 32'h0000_0000;

  // Read register clears when no read is pending
  // A zero idle value keeps stale words off the bus
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= RD ? rd_mux : 32'h0000_0000;
    end
  end

  assign RDATA = rdata_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Ticks are separated by at least three idle cycles
  sequence s_tick_gap;
    !tick [*3];
  endsequence

  // Two-input run: three consecutive abnormal samples are needed
  sequence s_two_arm;
    (run_cnt == 9'h002) && sample && abnormal && mode_two && !run_clear;
  endsequence

  // One-input run: the abnormal check taken now is the five hundredth
  sequence s_one_arm;
    (run_cnt == 9'h1F3) && sample && abnormal && mode_one && !run_clear;
  endsequence

  // A counting step: an abnormal check below the threshold
  sequence s_run_step;
    sample && abnormal && !run_reached && !run_clear;
  endsequence

  a_tick_spacing: assert property (@(posedge CLK) disable iff (!RST_N)
    tick |=> s_tick_gap) else $error("sampling ticks too close"); // see R3

  a_fail_needs_active: assert property (@(posedge CLK) disable iff (!RST_N)
    fail_ff |-> $past(active)) else $error("failure shown while not active"); // see R10

  a_two_threshold: assert property (@(posedge CLK) disable iff (!RST_N)
    s_two_arm |=> ##1 fail_ff) else $error("two-input failure not raised on third sample"); // see R4

  a_two_not_early: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(fail_ff) && mode_two |-> $past(run_cnt, 2) == 9'h002) else $error("two-input failure raised early"); // see R4

  a_one_not_early: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(fail_ff) && mode_one |-> $past(run_cnt, 2) == 9'h1F3) else $error("one-input failure count wrong"); // see R7

  a_healthy_resets: assert property (@(posedge CLK) disable iff (!RST_N)
    sample && !abnormal |=> run_cnt == 9'h000 ##1 !fail_ff) else $error("healthy sample kept run or failure"); // see R15

  a_sysfault_holds: assert property (@(posedge CLK) disable iff (!RST_N)
    sysflt_s && !run_clear |=> $stable(run_cnt)) else $error("sample taken during system fault"); // see R9

  a_block_forces: assert property (@(posedge CLK) disable iff (!RST_N)
    block_s && mode_on && enable |=> SUPV_BLOCKED_STATE ##1 !fail_ff) else $error("block not honoured"); // see R14

  a_mismatch_msg: assert property (@(posedge CLK) disable iff (!RST_N)
    mismatch && enable |=> CONFIG_MISMATCH && !SUPV_ACTIVE_STATE) else $error("mismatch not reported"); // see R12

  a_off_when_disabled: assert property (@(posedge CLK) disable iff (!RST_N)
    !enable |=> SUPV_OFF_STATE ##1 !FAIL_ANNUNCIATION) else $error("supervision not off"); // see R11

  a_irq_set_wins: assert property (@(posedge CLK) disable iff (!RST_N)
    irq_event[0] && wr_istat |=> irq_stat_ff[0]) else $error("event lost to clear"); // see R4

  a_one_threshold: assert property (@(posedge CLK) disable iff (!RST_N)
    s_one_arm |=> ##1 fail_ff) else $error("one-input failure not raised on last sample"); // see R7

  a_run_increments: assert property (@(posedge CLK) disable iff (!RST_N)
    s_run_step |=> run_cnt == $past(run_cnt) + 9'h001) else $error("abnormal check not counted"); // see R15

  // Only a taken check may lengthen the run
  a_run_grows_sampled: assert property (@(posedge CLK) disable iff (!RST_N)
    !sample |=> run_cnt <= $past(run_cnt)) else $error("run grew without a check"); // see R9

  // A new mode starts from an empty run with no annunciation
  a_mode_change_clears: assert property (@(posedge CLK) disable iff (!RST_N)
    mode != mode_last_ff |=> !fail_ff && run_cnt == 9'h000) else $error("mode change kept the run"); // see R10

  // Read data stand one cycle only, so a stale word never leaks
  a_rdata_idle_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    !$past(RD) |-> RDATA == 32'h0000_0000) else $error("read data outside read cycle"); // see R14

endmodule

/* File: tb/tcs_contacts_model.sv */
// Trip circuit wiring seen by the supervisor as two contact-sense levels
`timescale 1ns/10ps
module tcs_contacts_model (
  input wire logic trip_closed,
  input wire logic brk_closed,
  input wire logic ckt_ok,
  output logic trip_sense,
  output logic aux_sense
);
  // ----------------------------------------------------------------
  // Sense levels
  // ----------------------------------------------------------------
  // Trip sense is lit only while the trip contact is open and the loop is whole
  assign trip_sense = ckt_ok & ~trip_closed;
  // Aux sense is lit through the open-breaker contact; a closed trip contact shorts it
  assign aux_sense = ckt_ok & ~trip_closed & ~brk_closed;
endmodule

/* File: tb/trip_circuit_supervisor_bench.sv */
// Self-checking bench for the trip circuit supervisor
`timescale 1ns/10ps
module trip_circuit_supervisor_bench;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  localparam int P = 8; // Short sample period keeps the 500-sample run brief
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic trip_closed = 1'b0; // Relay trip contact
  logic brk_closed = 1'b1; // Breaker position
  logic ckt_ok = 1'b1; // Trip loop intact
  logic block_in = 1'b0;
  logic sys_fault = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic trip_sense, aux_sense, fail, st_off, st_blk, st_act, mism, irq;
  logic [31:0] rdata;
  int n_errors = 0;
  int samples_checked = 0;

  // Free-running system clock
  always #5 clk = ~clk;

  tcs_contacts_model tcs_contacts_model_i (.trip_closed(trip_closed), .brk_closed(brk_closed),
    .ckt_ok(ckt_ok), .trip_sense(trip_sense), .aux_sense(aux_sense));

  trip_circuit_supervisor #(.SAMPLE_PERIOD_CYC(P)) trip_circuit_supervisor_i (.CLK(clk), .RST_N(rst_n),
    .TRIP_CONTACT_SENSE_INPUT(trip_sense), .BREAKER_AUX_SENSE_INPUT(aux_sense), .BLOCK_INPUT(block_in),
    .SYSTEM_FAULT(sys_fault), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .FAIL_ANNUNCIATION(fail), .SUPV_OFF_STATE(st_off), .SUPV_BLOCKED_STATE(st_blk),
    .SUPV_ACTIVE_STATE(st_act), .CONFIG_MISMATCH(mism), .IRQ(irq));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Compare and count; case inequality so an unknown never matches
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // One-cycle read strobe; data stands only in the following cycle
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // Wiring state of the far side, changed on an edge
  task automatic set_loop(input logic t, input logic b, input logic c);
    @(posedge clk);
    trip_closed <= t;
    brk_closed <= b;
    ckt_ok <= c;
  endtask

  // Bounded wait for the annunciation level, timed against a window
  task automatic wait_fail(input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while (fail !== lvl && n <= hi) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n >= lo && n <= hi, 1);
    if (n > hi) end_sim();
  endtask

  // Annunciation must stay low throughout
  task automatic hold_low(input int cyc);
    logic seen;
    seen = 1'b0;
    repeat (cyc) begin
      @(posedge clk);
      #1;
      seen = seen | (fail !== 1'b0);
    end
    chk(seen, 0);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    idle(1);
    chk({st_off, st_blk, st_act, fail, irq}, 5'b10000);
    rd_chk(tcs_pkg::CFG_OFFSET, 32'h0000_0004);
    wr_reg(tcs_pkg::STATUS_OFFSET, 32'hFFFF_FFFF);
    rd_chk(tcs_pkg::STATUS_OFFSET, 32'h0000_0002);
    rd_chk(tcs_pkg::IRQ_MASK_OFFSET, 32'h0000_0000);
    rd_chk(8'h10, 32'h0000_0000);
    $display("Test reset done");
  endtask

  task automatic t_two();
    wr_reg(tcs_pkg::IRQ_MASK_OFFSET, 32'h0000_0003);
    wr_reg(tcs_pkg::CFG_OFFSET, 32'h0000_001D);
    idle(3);
    chk({st_off, st_blk, st_act}, 3'b001);
    // Trip pulse shorter than three samples
    set_loop(1'b1, 1'b1, 1'b1);
    hold_low(2*P-2);
    set_loop(1'b0, 1'b1, 1'b1);
    hold_low(4*P);
    // Broken run cut by one healthy sample, so the count restarts
    set_loop(1'b0, 1'b1, 1'b0);
    idle(2*P-2);
    set_loop(1'b0, 1'b1, 1'b1);
    idle(P+2);
    set_loop(1'b0, 1'b1, 1'b0);
    wait_fail(1'b1, 2*P+2, 3*P+4);
    chk(irq, 1);
    set_loop(1'b0, 1'b0, 1'b1);
    wait_fail(1'b0, 1, P+4);
    set_loop(1'b1, 1'b0, 1'b1);
    wait_fail(1'b1, 2*P+2, 3*P+4);
    set_loop(1'b0, 1'b1, 1'b1);
    wait_fail(1'b0, 1, P+4);
    rd_chk(tcs_pkg::IRQ_STAT_OFFSET, 32'h0000_0003);
    wr_reg(tcs_pkg::IRQ_STAT_OFFSET, 32'h0000_0003);
    rd_chk(tcs_pkg::IRQ_STAT_OFFSET, 32'h0000_0000);
    chk(irq, 0);
    $display("Test two inputs done");
  endtask

  task automatic t_one();
    wr_reg(tcs_pkg::CFG_OFFSET, 32'h0000_000E);
    idle(3);
    // Long trip command must not annunciate
    set_loop(1'b1, 1'b1, 1'b1);
    hold_low(100*P);
    // One healthy check ends that run before the broken loop is timed
    set_loop(1'b0, 1'b1, 1'b1);
    idle(P+2);
    set_loop(1'b0, 1'b1, 1'b0);
    wait_fail(1'b1, 499*P+2, 500*P+4);
    set_loop(1'b0, 1'b0, 1'b1);
    wait_fail(1'b0, 1, P+4);
    $display("Test one input done");
  endtask

  task automatic t_gate();
    logic [31:0] cfgs [3] = '{32'h0000_0019, 32'h0000_001F, 32'h0000_001C};
    set_loop(1'b0, 1'b1, 1'b0);
    // Enable off, reserved mode, disabled mode: no supervision
    foreach (cfgs[i]) begin
      wr_reg(tcs_pkg::CFG_OFFSET, cfgs[i]);
      hold_low(4*P);
      chk(st_off, 1);
    end
    @(posedge clk);
    block_in <= 1'b1;
    wr_reg(tcs_pkg::CFG_OFFSET, 32'h0000_001D);
    hold_low(4*P);
    chk(st_blk, 1);
    @(posedge clk);
    block_in <= 1'b0;
    sys_fault <= 1'b1;
    hold_low(5*P);
    chk(st_act, 1);
    @(posedge clk);
    sys_fault <= 1'b0;
    wait_fail(1'b1, 2*P+2, 3*P+4);
    set_loop(1'b0, 1'b1, 1'b1);
    wait_fail(1'b0, 1, P+4);
    $display("Test gating done");
  endtask

  task automatic t_mismatch();
    wr_reg(tcs_pkg::IRQ_MASK_OFFSET, 32'h0000_0004);
    wr_reg(tcs_pkg::CFG_OFFSET, 32'h0000_000D);
    idle(3);
    chk({st_blk, mism, irq}, 3'b111);
    rd_chk(tcs_pkg::STATUS_OFFSET, 32'h0000_0014);
    wr_reg(tcs_pkg::IRQ_MASK_OFFSET, 32'h0000_0000);
    idle(1);
    chk(irq, 0);
    wr_reg(tcs_pkg::IRQ_STAT_OFFSET, 32'h0000_0004);
    // Only the written bit clears; the earlier failure events stay
    rd_chk(tcs_pkg::IRQ_STAT_OFFSET, 32'h0000_0003);
    wr_reg(tcs_pkg::CFG_OFFSET, 32'h0000_001E);
    idle(3);
    chk(mism, 1);
    wr_reg(tcs_pkg::CFG_OFFSET, 32'h0000_001D);
    idle(3);
    chk({st_act, mism}, 2'b10);
    $display("Test mismatch done");
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_two();
    t_one();
    t_gate();
    t_mismatch();
    end_sim();
  end
endmodule
